// file: core/chg_deglitch.sv
// raises its output only after the input has stood high for CYCLES clocks
`timescale 1ns/1ns
module chg_deglitch #(
    parameter int unsigned CYCLES = 1
) (
    input wire logic core_clk, // clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic level, // synchronised condition
    output logic held // condition has persisted
);
    import chg_pkg::*;

    localparam int unsigned CW = $clog2(CYCLES + 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic held;
    } chg_dgl_s;

    chg_dgl_s s;
    chg_dgl_s next_s;

    // release is immediate; only the onset is filtered
    always_comb
    begin
        next_s = s;
        if (!level)
        begin
            next_s.cnt = '0;
            next_s.held = 1'b0;
        end
        else if (!s.held)
        begin
            if (s.cnt == CW'(CYCLES - 1))
                next_s.held = 1'b1;
            else
                next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    assign held = s.held;
endmodule : chg_deglitch

// file: core/chg_status_fault.sv
// charger mode sequencing, fault handling and open-drain status outputs
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "chg_defines.svh"
module chg_status_fault #(
    parameter int unsigned TICK_CYCLES = `CHG_TICK_CYCLES,
    parameter int unsigned PRECHG_MS = `CHG_PRECHG_MS,
    parameter int unsigned FAST_MS = `CHG_FAST_MS,
    parameter int unsigned BLINK_HALF_MS = `CHG_BLINK_HALF_MS,
    parameter int unsigned IN_OV_DGL_CYCLES = `CHG_IN_OV_DGL_CYCLES,
    parameter int unsigned OC_DGL_CYCLES = `CHG_OC_DGL_CYCLES
) (
    input wire logic core_clk, // 125 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic inAboveLowV, // input above low_input_threshold
    input wire logic inAboveSleep, // input above output plus sleep_offset
    input wire logic inOverVoltage, // input above input_overvoltage_threshold
    input wire logic outOverVoltage, // output above output_overvoltage_threshold
    input wire logic outOverCurrent, // current above overcurrent_threshold
    input wire logic thermalFoldBack, // thermal_fold_back active
    input wire logic thermalCutoff, // thermal_cutoff flag, hysteretic
    input wire logic thermBelowDisable, // thermistor pin below disable threshold
    input wire logic thermAboveEnable, // thermistor pin above enable threshold
    input wire logic batteryTooHot, // battery_too_hot
    input wire logic batteryTooCold, // battery_too_cold
    input wire logic outAboveRecharge, // output above recharge_threshold
    input wire logic currentBelowTerm, // charge current below termination level
    input wire logic outBelowLowV, // output in precharge region
    input wire logic voltageProgFault, // voltage_program_pin short or open
    input wire logic currentProgShort, // current_program_pin short
    output logic regulatorEn, // linear regulator enable
    input wire logic powerGoodIn, // power_good_out pin level
    output logic powerGoodOut, // power_good_out drive value
    output logic powerGoodOe, // power_good_out pulls low
    input wire logic statIn, // progress pin level
    output logic statOut, // progress pin drive value
    output logic statOe, // progress pin pulls low
    input wire logic [`CHG_ADDR_W-1:0] regAddr, // register byte address
    input wire logic [31:0] regWdata, // register write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output logic irq // level interrupt
);
    import chg_pkg::*;

    typedef struct packed {
        chg_mode_e mode;
        logic done;
        logic ocLatch;
        logic progLatch;
        logic tmrExp;
        logic [16:0] tickCnt;
        logic halfPhase;
        logic [25:0] timer;
        logic lowVPrev;
        logic [9:0] blinkCnt;
        logic blinkPhase;
        logic blinkPrev;
        logic pgOe;
        logic statOe;
        logic regEn;
        logic [`CHG_NEV-1:0] intStat;
        logic [`CHG_NEV-1:0] intMask;
        logic [31:0] rdata;
    } chg_state_s;

    chg_state_s s;
    chg_state_s next_s;

    chg_flag_if flags ();
    logic inOvHeld;
    logic ocHeld;

    assign flags.raw = {currentProgShort, voltageProgFault, outBelowLowV, currentBelowTerm,
        outAboveRecharge, batteryTooCold, batteryTooHot, thermAboveEnable,
        thermBelowDisable, thermalCutoff, thermalFoldBack, outOverCurrent,
        outOverVoltage, inOverVoltage, inAboveSleep, inAboveLowV};

    // every comparator is asynchronous to the clock
    chg_sync u_sync (
        .core_clk (core_clk),
        .rst_b (rst_b),
        .flags (flags.sync_side)
    );

    chg_deglitch #(.CYCLES(IN_OV_DGL_CYCLES)) u_in_ov_dgl (
        .core_clk (core_clk),
        .rst_b (rst_b),
        .level (flags.synced[`CHG_FL_IN_OV]),
        .held (inOvHeld)
    );

    chg_deglitch #(.CYCLES(OC_DGL_CYCLES)) u_oc_dgl (
        .core_clk (core_clk),
        .rst_b (rst_b),
        .level (flags.synced[`CHG_FL_OUT_OC]),
        .held (ocHeld)
    );

    logic inLow, inSleep, inOv, outOv, fold, cutoff, thDis, thEn;
    logic hot, cold, rechg, term, lowV, vprog, iprog;
    assign inLow = flags.synced[`CHG_FL_IN_LOW];
    assign inSleep = flags.synced[`CHG_FL_IN_SLEEP];
    assign inOv = flags.synced[`CHG_FL_IN_OV];
    assign outOv = flags.synced[`CHG_FL_OUT_OV];
    assign fold = flags.synced[`CHG_FL_FOLD];
    assign cutoff = flags.synced[`CHG_FL_CUTOFF];
    assign thDis = flags.synced[`CHG_FL_TH_DIS];
    assign thEn = flags.synced[`CHG_FL_TH_EN];
    assign hot = flags.synced[`CHG_FL_HOT];
    assign cold = flags.synced[`CHG_FL_COLD];
    assign rechg = flags.synced[`CHG_FL_RECHG];
    assign term = flags.synced[`CHG_FL_TERM];
    assign lowV = flags.synced[`CHG_FL_OUT_LOWV];
    assign vprog = flags.synced[`CHG_FL_VPROG];
    assign iprog = flags.synced[`CHG_FL_IPROG];

    logic tick;
    logic softFault;
    logic hardFault;
    logic blinkFault;
    logic advance;
    logic rechargeStart;
    logic doneSet;
    logic [25:0] limit;
    logic [`CHG_NEV-1:0] events;
    logic [`CHG_NEV-1:0] w1c;

    always_comb
    begin
        next_s = s;
        next_s.rdata = '0;
        w1c = '0;

        // free-running millisecond tick for the slow timers
        tick = (s.tickCnt == 17'(TICK_CYCLES - 1));
        next_s.tickCnt = tick ? 17'h00000 : s.tickCnt + 17'h00001;

        softFault = inOvHeld || outOv || hot || cold;
        hardFault = s.ocLatch || s.progLatch || s.tmrExp;

        // mode sequencing; input overvoltage is seen only once deglitched
        if (!inLow || thDis)
            next_s.mode = CHG_SHUTDOWN;
        else if (s.mode == CHG_SHUTDOWN && !thEn)
            next_s.mode = CHG_SHUTDOWN;
        else if (hardFault)
            next_s.mode = CHG_FAULT;
        else if (!inSleep)
            next_s.mode = CHG_SLEEP;
        else if (softFault || cutoff || s.done)
            next_s.mode = CHG_STANDBY;
        else
            next_s.mode = CHG_ACTIVE;

        // the regulator also drops at once on output overvoltage or cutoff
        next_s.regEn = (next_s.mode == CHG_ACTIVE) && !outOv && !cutoff;

        // termination is blocked while folding back
        doneSet = (s.mode == CHG_ACTIVE) && rechg && term && !fold;
        rechargeStart = s.done && !rechg;
        if (doneSet)
            next_s.done = 1'b1;
        else if (rechargeStart)
            next_s.done = 1'b0;

        // latched faults; a toggle of supply or thermistor passes through shutdown
        if (s.mode == CHG_ACTIVE && ocHeld)
            next_s.ocLatch = 1'b1;
        if (s.mode != CHG_SHUTDOWN && (vprog || iprog))
            next_s.progLatch = 1'b1;

        // safety timer: counts only while charging, paused by any standby cause
        advance = tick && (s.mode == CHG_ACTIVE) && (!fold || s.halfPhase);
        if (tick && s.mode == CHG_ACTIVE && fold)
            next_s.halfPhase = !s.halfPhase;
        limit = lowV ? 26'(PRECHG_MS - 1) : 26'(FAST_MS - 1);
        next_s.lowVPrev = lowV;
        if (advance)
        begin
            if (s.timer >= limit)
                next_s.tmrExp = 1'b1;
            else
                next_s.timer = s.timer + 26'h0000001;
        end
        // restart on new cycle, on crossing the precharge boundary, or on overcurrent
        if (rechargeStart || (lowV != s.lowVPrev) || (ocHeld && s.mode == CHG_ACTIVE))
        begin
            next_s.timer = '0;
            next_s.halfPhase = 1'b0;
        end

        if (s.mode == CHG_SHUTDOWN)
        begin
            next_s.done = 1'b0;
            next_s.ocLatch = 1'b0;
            next_s.progLatch = 1'b0;
            next_s.tmrExp = 1'b0;
            next_s.timer = '0;
            next_s.halfPhase = 1'b0;
        end

        // blink divider: equal halves, restarted whenever the fault set clears
        blinkFault = (s.mode == CHG_FAULT) || (s.mode != CHG_SHUTDOWN && softFault);
        if (!blinkFault)
        begin
            next_s.blinkCnt = '0;
            next_s.blinkPhase = 1'b0;
        end
        else if (tick)
        begin
            if (s.blinkCnt == 10'(BLINK_HALF_MS - 1))
            begin
                next_s.blinkCnt = '0;
                next_s.blinkPhase = !s.blinkPhase;
            end
            else
                next_s.blinkCnt = s.blinkCnt + 10'h001;
        end
        next_s.blinkPrev = blinkFault;

        // open-drain drives; shutdown releases everything
        next_s.pgOe = (s.mode != CHG_SHUTDOWN) && inLow && inSleep && !inOv;
        if (next_s.mode == CHG_SHUTDOWN)
            next_s.statOe = 1'b0;
        else if (blinkFault)
            next_s.statOe = next_s.blinkPhase;
        else if (next_s.mode == CHG_ACTIVE || (next_s.mode == CHG_STANDBY && !next_s.done))
            next_s.statOe = 1'b1;
        else
            next_s.statOe = 1'b0;

        // sticky interrupt events
        events = '0;
        events[`CHG_EV_DONE] = doneSet && !s.done;
        events[`CHG_EV_FAULT] = (next_s.mode == CHG_FAULT) && (s.mode != CHG_FAULT);
        events[`CHG_EV_BLINK] = blinkFault && !s.blinkPrev;
        events[`CHG_EV_PG] = next_s.pgOe != s.pgOe;
        events[`CHG_EV_RECHG] = rechargeStart;

        // register access
        if (regWr)
        begin
            if (regAddr == `CHG_OFS_INT_STAT)
                w1c = regWdata[`CHG_NEV-1:0];
            else if (regAddr == `CHG_OFS_INT_MASK)
                next_s.intMask = regWdata[`CHG_NEV-1:0];
        end
        // a new event wins over a clear in the same cycle
        next_s.intStat = (s.intStat & ~w1c) | events;

        if (regRd)
        begin
            if (regAddr == `CHG_OFS_STATUS)
            begin
                next_s.rdata[`CHG_ST_MODE_MSB:`CHG_ST_MODE_LSB] = s.mode;
                next_s.rdata[`CHG_ST_DONE] = s.done;
                next_s.rdata[`CHG_ST_BLINK] = blinkFault;
                next_s.rdata[`CHG_ST_TIMER_EXPIRED] = s.tmrExp;
                next_s.rdata[`CHG_ST_OC_LATCH] = s.ocLatch;
                next_s.rdata[`CHG_ST_PROG_LATCH] = s.progLatch;
                next_s.rdata[`CHG_ST_PG_PIN] = powerGoodIn;
                next_s.rdata[`CHG_ST_STAT_PIN] = statIn;
                next_s.rdata[`CHG_ST_FOLD] = fold;
                next_s.rdata[`CHG_ST_CUTOFF] = cutoff;
            end
            else if (regAddr == `CHG_OFS_INT_STAT)
                next_s.rdata[`CHG_NEV-1:0] = s.intStat;
            else if (regAddr == `CHG_OFS_INT_MASK)
                next_s.rdata[`CHG_NEV-1:0] = s.intMask;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.intMask <= `CHG_INT_MASK_RST;
        end
        else
            s <= next_s;
    end

    assign regulatorEn = s.regEn;
    assign powerGoodOut = 1'b0;
    assign powerGoodOe = s.pgOe;
    assign statOut = 1'b0;
    assign statOe = s.statOe;
    assign regRdata = s.rdata;
    assign irq = |(s.intStat & s.intMask);
endmodule : chg_status_fault

// file: core/chg_sync.sv
// two-flop synchroniser for the analog comparator flags
`timescale 1ns/1ns
module chg_sync (
    input wire logic core_clk, // clock
    input wire logic rst_b, // synchronous reset, active low
    chg_flag_if.sync_side flags // raw flags in, synced flags out
);
    import chg_pkg::*;

    chg_sync_s s;
    chg_sync_s next_s;

    // stage1 feeds stage2 only
    always_comb
    begin
        next_s.stage1 = flags.raw;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    assign flags.synced = s.stage2;
endmodule : chg_sync

// file: dv/chg_pin_model.sv
// pull-up load on the two open-drain indicator pins
`timescale 1ns/1ns
module chg_pin_model (
    input wire logic powerGoodOut, // drive value
    input wire logic powerGoodOe, // pulls the pin
    input wire logic statOut, // drive value
    input wire logic statOe, // pulls the pin
    output logic powerGoodIn, // resolved level
    output logic statIn // resolved level
);
    // a released pin rises through its pull-up, it never keeps a stale level
    assign powerGoodIn = powerGoodOe ? powerGoodOut : 1'b1;
    assign statIn = statOe ? statOut : 1'b1;
endmodule : chg_pin_model

// file: dv/chg_status_fault_props.sv
// concurrent checks on the charger controller ports
`timescale 1ns/1ns
module chg_status_fault_props (
    input wire logic core_clk, // clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic inAboveLowV, // input above low threshold
    input wire logic inAboveSleep, // input above output plus offset
    input wire logic inOverVoltage, // input overvoltage
    input wire logic outOverVoltage, // output overvoltage
    input wire logic thermalCutoff, // die cutoff flag
    input wire logic thermBelowDisable, // thermistor disable
    input wire logic thermAboveEnable, // thermistor enable
    input wire logic regulatorEn, // regulator on
    input wire logic powerGoodOut, // drive value
    input wire logic powerGoodOe, // power good pulls low
    input wire logic statOut, // drive value
    input wire logic statOe, // progress pulls low
    input wire logic regRd, // read strobe
    input wire logic [31:0] regRdata // read data
);
    // histories give the two sync flops and the state edge room either way
    logic [5:0] offH;
    logic [5:0] okH;
    logic [5:0] sdH;
    logic [5:0] slH;
    logic [5:0] cutH;
    logic [3:0] age;
    always_ff @(posedge core_clk)
    begin
        offH <= {offH[4:0], !inAboveLowV || !inAboveSleep || thermBelowDisable};
        okH <= {okH[4:0], inAboveLowV && inAboveSleep && !inOverVoltage &&
            thermAboveEnable && !thermBelowDisable};
        sdH <= {sdH[4:0], !inAboveLowV || thermBelowDisable};
        slH <= {slH[4:0], !inAboveSleep};
        cutH <= {cutH[4:0], thermalCutoff};
        age <= !rst_b ? 4'h0 : age + {3'h0, age != 4'hf};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    pg_release_a: assert property (&offH[5:1] |-> !powerGoodOe)
        else $error("power good pulled with bad input");
    pg_drive_a: assert property (&okH[5:1] && age > 4'h9 |-> powerGoodOe)
        else $error("power good released with good input");
    od_low_a: assert property (!powerGoodOut && !statOut)
        else $error("open-drain drive value not low");
    shutdown_quiet_a: assert property (&sdH[5:1] |-> !regulatorEn && !statOe && !powerGoodOe)
        else $error("pins active in shutdown");
    sleep_idle_a: assert property (&slH[5:1] |-> !regulatorEn && !statOe)
        else $error("charging or progress low in sleep");
    ovp_stop_a: assert property (outOverVoltage [*6] |-> ##1 !regulatorEn)
        else $error("regulator on during output overvoltage");
    cutoff_stop_a: assert property (&cutH[5:1] |-> !regulatorEn)
        else $error("regulator on during cutoff");
    charge_stat_a: assert property (regulatorEn |-> statOe)
        else $error("progress released while charging");
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule : chg_status_fault_props
bind chg_status_fault chg_status_fault_props chg_status_fault_props_inst (.core_clk, .rst_b,
    .inAboveLowV, .inAboveSleep, .inOverVoltage, .outOverVoltage, .thermalCutoff,
    .thermBelowDisable, .thermAboveEnable, .regulatorEn, .powerGoodOut, .powerGoodOe,
    .statOut, .statOe, .regRd, .regRdata);

// file: dv/testbench.sv
// self-checking bench of the charger status and fault controller
`timescale 1ns/1ns
module testbench;
    localparam int TK = 4;
    localparam int BH = 3;
    localparam int PM = 20;
    localparam int FM = 50;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic inAboveLowV = 1'b0;
    logic inAboveSleep = 1'b0;
    logic [3:0] recF = 4'h0;
    logic [2:0] latF = 3'h0;
    logic thermalFoldBack = 1'b0;
    logic thermalCutoff = 1'b0;
    logic thermBelowDisable = 1'b1;
    logic thermAboveEnable = 1'b0;
    logic outAboveRecharge = 1'b0;
    logic currentBelowTerm = 1'b0;
    logic outBelowLowV = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic regulatorEn, powerGoodIn, powerGoodOut, powerGoodOe, statIn, statOut, statOe, irq;
    int miscompares = 0;
    int cmpCount = 0;
    chg_status_fault #(.TICK_CYCLES(TK), .PRECHG_MS(PM), .FAST_MS(FM), .BLINK_HALF_MS(BH),
        .IN_OV_DGL_CYCLES(5), .OC_DGL_CYCLES(3)) chg_status_fault_inst (.core_clk, .rst_b,
        .inAboveLowV, .inAboveSleep, .inOverVoltage(recF[0]), .outOverVoltage(recF[1]),
        .outOverCurrent(latF[0]), .thermalFoldBack, .thermalCutoff, .thermBelowDisable,
        .thermAboveEnable, .batteryTooHot(recF[2]), .batteryTooCold(recF[3]),
        .outAboveRecharge, .currentBelowTerm, .outBelowLowV, .voltageProgFault(latF[2]),
        .currentProgShort(latF[1]), .regulatorEn, .powerGoodIn, .powerGoodOut, .powerGoodOe,
        .statIn, .statOut, .statOe, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);
    chg_pin_model chg_pin_model_inst (.powerGoodOut, .powerGoodOe, .statOut, .statOe,
        .powerGoodIn, .statIn);
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic mode(input logic [2:0] e);
        logic [31:0] d;
        rd(8'h00, d);
        chk(d[2:0], e);
    endtask : mode
    task automatic halfp(output int n);
        logic s;
        s = statOe;
        n = 0;
        while (statOe === s && n < 40)
        begin
            cyc(1);
            n++;
        end
    endtask : halfp
    // first half may be partial, so only the two following halves are timed
    task automatic blink;
        int n;
        halfp(n);
        halfp(n);
        chk(n, BH * TK);
        halfp(n);
        chk(n, BH * TK);
    endtask : blink
    task automatic restart(input logic ts);
        @(posedge core_clk);
        inAboveLowV <= ts;
        thermBelowDisable <= ts;
        thermAboveEnable <= !ts;
        cyc(8);
        chk({regulatorEn, statOe, powerGoodOe}, 3'b000);
        mode(3'd0);
        @(posedge core_clk);
        inAboveLowV <= 1'b1;
        thermBelowDisable <= 1'b0;
        thermAboveEnable <= 1'b1;
        cyc(8);
        chk(regulatorEn, 1'b1);
    endtask : restart
    task automatic t_reset;
        logic [31:0] d;
        cyc(1);
        chk({regulatorEn, statOe, powerGoodOe, irq}, 4'h0);
        mode(3'd0);
        rd(8'h08, d);
        chk(d, 32'h0);
        wr(8'h08, 32'hffffffff);
        rd(8'h08, d);
        chk(d, 32'h1f);
        rd(8'h0c, d);
        chk(d, 32'h0);
        @(posedge core_clk);
        thermBelowDisable <= 1'b0;
        inAboveLowV <= 1'b1;
        inAboveSleep <= 1'b1;
        cyc(10);
        mode(3'd0);
        @(posedge core_clk);
        thermAboveEnable <= 1'b1;
        cyc(6);
        chk({regulatorEn, statOe, powerGoodOe, statIn, powerGoodIn}, 5'b11100);
        mode(3'd2);
        @(posedge core_clk);
        inAboveSleep <= 1'b0;
        cyc(6);
        chk({regulatorEn, statOe, powerGoodOe, statIn, powerGoodIn}, 5'b00011);
        mode(3'd1);
        @(posedge core_clk);
        inAboveSleep <= 1'b1;
        cyc(6);
        chk(regulatorEn, 1'b1);
        $display("power-up test done");
    endtask : t_reset
    task automatic t_recov;
        restart(1'b0);
        @(posedge core_clk);
        recF <= 4'h1;
        cyc(2);
        recF <= 4'h0;
        cyc(10);
        chk(regulatorEn, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            recF <= 4'h1 << i;
            cyc(6);
            if (i < 2) chk(regulatorEn, 1'(i == 0));
            cyc(10);
            chk({regulatorEn, powerGoodOe}, {1'b0, i != 0});
            mode(3'd3);
            blink;
            @(posedge core_clk);
            recF <= 4'h0;
            cyc(6);
            chk({regulatorEn, statOe}, 2'b11);
        end
        $display("recoverable fault test done");
    endtask : t_recov
    task automatic t_latch;
        logic [31:0] d;
        for (int j = 0; j < 3; j++)
        begin
            restart(1'(j == 1));
            @(posedge core_clk);
            latF <= 3'h1 << j;
            cyc(10);
            latF <= 3'h0;
            cyc(20);
            chk(regulatorEn, 1'b0);
            rd(8'h00, d);
            chk({d[7:6], d[2:0]}, {j != 0, j == 0, 3'd4});
            rd(8'h04, d);
            chk(d[2:1], 2'b11);
            blink;
        end
        restart(1'b1);
        $display("latched fault test done");
    endtask : t_latch
    task automatic t_term;
        logic [31:0] d;
        restart(1'b0);
        wr(8'h08, 32'h11);
        wr(8'h04, 32'h1f);
        @(posedge core_clk);
        thermalCutoff <= 1'b1;
        cyc(6);
        chk({regulatorEn, statOe, irq}, 3'b010);
        thermalCutoff <= 1'b0;
        outAboveRecharge <= 1'b1;
        currentBelowTerm <= 1'b1;
        thermalFoldBack <= 1'b1;
        cyc(10);
        chk(regulatorEn, 1'b1);
        thermalFoldBack <= 1'b0;
        cyc(6);
        chk({regulatorEn, statOe, powerGoodOe, irq}, 4'b0011);
        rd(8'h00, d);
        chk({d[3], d[2:0]}, {1'b1, 3'd3});
        wr(8'h04, 32'h1);
        cyc(1);
        chk(irq, 1'b0);
        outAboveRecharge <= 1'b0;
        currentBelowTerm <= 1'b0;
        cyc(6);
        chk({regulatorEn, statOe, irq}, 3'b111);
        wr(8'h08, 32'h0);
        cyc(1);
        chk(irq, 1'b0);
        $display("termination test done");
    endtask : t_term
    task automatic t_timer;
        logic [31:0] d;
        int lim;
        for (int i = 0; i < 3; i++)
        begin
            lim = (i == 1 ? PM : FM) * TK * (i == 2 ? 2 : 1);
            @(posedge core_clk);
            outBelowLowV <= (i == 1);
            thermalFoldBack <= (i == 2);
            restart(1'b0);
            cyc(lim - 16);
            chk(regulatorEn, 1'b1);
            cyc(24);
            rd(8'h00, d);
            chk({regulatorEn, d[5]}, 2'b01);
            blink;
        end
        @(posedge core_clk);
        outBelowLowV <= 1'b0;
        thermalFoldBack <= 1'b0;
        restart(1'b0);
        $display("safety timer test done");
    endtask : t_timer
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset;
        t_recov;
        t_latch;
        t_term;
        t_timer;
        stop_test;
    end
    initial
    begin
        #120000;
        miscompares++;
        stop_test;
    end
endmodule : testbench

// file: inc/chg_defines.svh
// constants of the charger status and fault controller
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

// clock rate
`define CHG_CLK_MHZ 125

// comparator flag positions in the synchronised vector
`define CHG_NFLAGS 16
`define CHG_FL_IN_LOW 0
`define CHG_FL_IN_SLEEP 1
`define CHG_FL_IN_OV 2
`define CHG_FL_OUT_OV 3
`define CHG_FL_OUT_OC 4
`define CHG_FL_FOLD 5
`define CHG_FL_CUTOFF 6
`define CHG_FL_TH_DIS 7
`define CHG_FL_TH_EN 8
`define CHG_FL_HOT 9
`define CHG_FL_COLD 10
`define CHG_FL_RECHG 11
`define CHG_FL_TERM 12
`define CHG_FL_OUT_LOWV 13
`define CHG_FL_VPROG 14
`define CHG_FL_IPROG 15

// register offsets (byte addresses)
`define CHG_ADDR_W 8
`define CHG_OFS_STATUS 8'h00
`define CHG_OFS_INT_STAT 8'h04
`define CHG_OFS_INT_MASK 8'h08

// status register fields
`define CHG_ST_MODE_LSB 0
`define CHG_ST_MODE_MSB 2
`define CHG_ST_DONE 3
`define CHG_ST_BLINK 4
`define CHG_ST_TIMER_EXPIRED 5
`define CHG_ST_OC_LATCH 6
`define CHG_ST_PROG_LATCH 7
`define CHG_ST_PG_PIN 8
`define CHG_ST_STAT_PIN 9
`define CHG_ST_FOLD 10
`define CHG_ST_CUTOFF 11

// interrupt event bits
`define CHG_NEV 5
`define CHG_EV_DONE 0
`define CHG_EV_FAULT 1
`define CHG_EV_BLINK 2
`define CHG_EV_PG 3
`define CHG_EV_RECHG 4
`define CHG_INT_MASK_RST 5'h00

// timing, each time in its own unit and the count derived from it
`define CHG_TICK_US 1000
`define CHG_TICK_CYCLES (`CHG_TICK_US * `CHG_CLK_MHZ)
`define CHG_PRECHG_MIN 30
`define CHG_PRECHG_MS (`CHG_PRECHG_MIN * 60 * 1000)
`define CHG_FAST_HOURS 10
`define CHG_FAST_MS (`CHG_FAST_HOURS * 3600 * 1000)
`define CHG_BLINK_HZ 1
`define CHG_BLINK_HALF_MS (1000 / (2 * `CHG_BLINK_HZ))
`define CHG_IN_OV_DGL_US 100
`define CHG_IN_OV_DGL_CYCLES (`CHG_IN_OV_DGL_US * `CHG_CLK_MHZ)
`define CHG_OC_DGL_US 10
`define CHG_OC_DGL_CYCLES (`CHG_OC_DGL_US * `CHG_CLK_MHZ)

`endif

// file: inc/chg_flag_if.sv
// comparator flags on their way through the synchroniser
`timescale 1ns/1ns
interface chg_flag_if;
    chg_pkg::chg_flags_t raw;
    chg_pkg::chg_flags_t synced;
    modport sync_side (input raw, output synced);
    modport user (output raw, input synced);
endinterface : chg_flag_if

// file: inc/chg_pkg.sv
// types of the charger status and fault controller
`include "chg_defines.svh"
package chg_pkg;
    typedef enum logic [2:0] {
        CHG_SHUTDOWN = 3'b000,
        CHG_SLEEP = 3'b001,
        CHG_ACTIVE = 3'b010,
        CHG_STANDBY = 3'b011,
        CHG_FAULT = 3'b100
    } chg_mode_e;

    typedef logic [`CHG_NFLAGS-1:0] chg_flags_t;

    typedef struct packed {
        chg_flags_t stage1;
        chg_flags_t stage2;
    } chg_sync_s;
endpackage : chg_pkg
